// *** include/nams_regs.svh ***
// constants for the nfc active mode sequencer
`ifndef NAMS_REGS_SVH
`define NAMS_REGS_SVH
`define NAMS_CLK_HZ 50000000
// collision avoidance sensing time, us
`define NAMS_CA_TIME_US 75
`define NAMS_CA_CYC ((`NAMS_CA_TIME_US * 50))
// initial guard time, us
`define NAMS_IRFG_TIME_US 5000
`define NAMS_IRFG_CYC ((`NAMS_IRFG_TIME_US * 50))
// active guard time, us
`define NAMS_ARFG_TIME_US 75
`define NAMS_ARFG_CYC ((`NAMS_ARFG_TIME_US * 50))
// rate codes
`define NAMS_RATE_106 2'h0
`define NAMS_RATE_212 2'h1
`define NAMS_RATE_424 2'h2
// transport frame start byte
`define NAMS_START_BYTE 8'hf0
`endif

// *** include/nams_pkg.sv ***
// types for the nfc active mode sequencer
package nams_pkg;
    typedef enum logic [7:0] {
        NAMS_IDLE = 8'h01,
        NAMS_CA = 8'h02,
        NAMS_GUARD = 8'h04,
        NAMS_TXON = 8'h08,
        NAMS_HOLD = 8'h10,
        NAMS_WAIT = 8'h20,
        NAMS_MASK = 8'h40,
        NAMS_RECV = 8'h80
    } nams_state_t;
    typedef struct packed {
        nams_state_t st;
        logic [19:0] cnt;
        logic resp;
        logic [3:0] nslot;
        logic tx_on;
        logic use_ca_thr;
        logic rx_watch;
        logic [1:0] det_rate;
        logic rate_ok;
        logic [1:0] def_rate;
        logic normal;
        logic [2:0] fd_s;
        logic [1:0] rxs_s;
        logic [1:0] rate_s0;
        logic [1:0] rate_s1;
        logic prev_fd;
        logic irq_cat;
        logic irq_cac;
        logic irq_eon;
        logic irq_eof;
        logic irq_nre;
        logic irq_sor;
        logic irq_nfct;
        logic lowpow;
        logic fde;
        logic [7:0] sbyte;
    } nams_regs_t;
endpackage

// *** hw/nams_core.sv ***
// nfc active mode field sequencer, initiator and target
// Notes on behaviour
// RULE1 - host picks active mode, target bit zero
// RULE2 - same bit rate both directions: 128/64/32
// RULE3 - auto response starts collision avoidance itself
// RULE4 - nfc mode enables field detector, peer threshold
// RULE5 - field-on command uses collision threshold
// RULE6 - only field-on commands set transmitter
// RULE7 - field off after message, gp timer delay
// RULE8 - preset enables am, disables pm
// RULE9 - preset sets transport frame enable
// RULE10 - host keeps slot count zero in loop
// RULE11 - initial field-on: field on, done after guard
// RULE12 - field off starts no-response timer
// RULE13 - peer field on: irq, mask timer, then watch
// RULE14 - peer field off: irq, auto response field-on
// RULE15 - host clears auto response before last command
// RULE16 - target bit enables field detector
// RULE17 - target, no operation bits: low power
// RULE18 - rate detection stores rate, normal uses definition
// RULE19 - start of receive, detect rate, then allow response
// RULE20 - host powers receiver, starts mask timer
// RULE21 - go-normal copies detected rate, normal mode
// RULE22 - slot count sets n in target
// RULE23 - transport frame prefixed with f0 start byte
// RULE24 - initiator loop is explicit state machine
`timescale 1ns/1ps
`default_nettype none
`include "nams_regs.svh"
module nams_core
    import nams_pkg::*;
(
    input wire logic clock,
    input wire logic rstn,
    input wire logic nfc_mode,
    input wire logic target_role,
    input wire logic rate_detect_mode,
    input wire logic [3:0] operation_bits,
    input wire logic auto_response_enable,
    input wire logic response_slot_count_hi,
    input wire logic response_slot_count_lo,
    input wire logic cmd_initial_field_on,
    input wire logic cmd_response_field_on,
    input wire logic cmd_start_mask_timer,
    input wire logic cmd_go_normal,
    input wire logic cmd_analog_preset,
    input wire logic tx_done,
    input wire logic [15:0] gp_timer,
    input wire logic [15:0] no_resp_timer,
    input wire logic [15:0] mask_timer,
    input wire logic field_detect_in,
    input wire logic rx_start_in,
    input wire logic [1:0] rate_in,
    output logic field_detector_enable,
    output logic collision_threshold_sel,
    output logic tx_enable,
    output logic rx_watch,
    output logic am_channel_enable,
    output logic pm_channel_enable,
    output logic transport_frame_enable,
    output logic [7:0] start_byte,
    output logic [1:0] detected_rate,
    output logic [1:0] bit_rate_def,
    output logic [1:0] clock_div_sel,
    output logic low_power,
    output logic irq_collision_done,
    output logic irq_collision_found,
    output logic irq_field_on,
    output logic irq_field_off,
    output logic irq_no_response,
    output logic irq_rx_start,
    output logic irq_rate_detected
);
    nams_regs_t r;
    nams_regs_t next_r;
    logic [2:0] preset_q;
    logic [2:0] next_preset_q;
    logic [1:0] div_q;
    logic [1:0] next_div_q;

    // divider select for the common tx and rx rate
    function automatic logic [1:0] rate_div(input logic [1:0] rate);
        rate_div = (rate == `NAMS_RATE_424) ? 2'h2 : (rate == `NAMS_RATE_212) ? 2'h1 : 2'h0;
    endfunction

    // cycle count from a 16-bit timer word
    function automatic logic [19:0] tcount(input logic [15:0] t);
        tcount = (t == 16'h0000) ? 20'h00001 : {4'h0, t};
    endfunction

    wire fd = r.fd_s[2];
    wire fd_rise = r.fd_s[2] & ~r.prev_fd;
    wire fd_fall = ~r.fd_s[2] & r.prev_fd;
    wire rx_go = r.rxs_s[1];

    // sequencer next state
    always_comb begin
        next_r = r;
        next_preset_q = preset_q;
        next_r.fd_s[2] = r.fd_s[1];
        next_r.fd_s[1] = r.fd_s[0];
        next_r.fd_s[0] = field_detect_in;
        next_r.prev_fd = r.fd_s[2];
        next_r.rxs_s = {r.rxs_s[0], rx_start_in};
        next_r.rate_s0 = rate_in;
        next_r.rate_s1 = r.rate_s0;
        next_r.irq_cat = 1'b0;
        next_r.irq_cac = 1'b0;
        next_r.irq_eon = 1'b0;
        next_r.irq_eof = 1'b0;
        next_r.irq_nre = 1'b0;
        next_r.irq_sor = 1'b0;
        next_r.irq_nfct = 1'b0;
        next_r.lowpow = target_role && (operation_bits == 4'h0); // [RULE17]
        next_r.fde = nfc_mode || target_role; // [RULE4] [RULE16]
        next_r.nslot = target_role ?
            {2'h0, response_slot_count_hi, response_slot_count_lo} : 4'h0; // [RULE22]
        if (cmd_analog_preset) begin
            next_preset_q = 3'b101; // am on, pm off, transport frame [RULE8] [RULE9]
        end
        next_r.sbyte = next_preset_q[0] ? `NAMS_START_BYTE : 8'h00; // [RULE23]
        if (cmd_go_normal && target_role) begin
            next_r.def_rate = r.det_rate; // [RULE21]
            next_r.normal = 1'b1;
        end
        if (!target_role) begin
            next_r.normal = 1'b0;
            next_r.rate_ok = 1'b0;
        end
        if (r.cnt != 20'h00000) begin
            next_r.cnt = r.cnt - 20'h00001;
        end
        case (r.st) // one state per loop step [RULE24]
            NAMS_IDLE: begin
                next_r.rx_watch = 1'b0;
                if (nfc_mode && (cmd_initial_field_on || cmd_response_field_on)) begin
                    next_r.st = NAMS_CA;
                    next_r.resp = cmd_response_field_on;
                    next_r.use_ca_thr = 1'b1; // [RULE5]
                    next_r.cnt = 20'(`NAMS_CA_CYC);
                end else if (target_role && fd_rise) begin
                    next_r.irq_eon = 1'b1; // first peer field in target
                    next_r.st = NAMS_WAIT;
                    next_r.cnt = 20'h00000;
                end
            end
            NAMS_CA: begin
                if (fd) begin
                    next_r.irq_cac = 1'b1;
                    next_r.use_ca_thr = 1'b0;
                    next_r.st = NAMS_IDLE;
                end else if (r.cnt == 20'h00000) begin
                    next_r.tx_on = 1'b1; // [RULE6] [RULE11]
                    next_r.use_ca_thr = 1'b0;
                    next_r.st = NAMS_GUARD;
                    next_r.cnt = r.resp ? 20'(`NAMS_ARFG_CYC) + {16'h0000, r.nslot} :
                        20'(`NAMS_IRFG_CYC);
                end
            end
            NAMS_GUARD: begin
                if (r.cnt == 20'h00000) begin
                    next_r.irq_cat = 1'b1; // [RULE11] [RULE14]
                    next_r.st = NAMS_TXON;
                end
            end
            NAMS_TXON: begin
                if (tx_done) begin
                    next_r.st = NAMS_HOLD;
                    next_r.cnt = tcount(gp_timer); // [RULE7]
                end
            end
            NAMS_HOLD: begin
                if (r.cnt == 20'h00000) begin
                    next_r.tx_on = 1'b0; // [RULE7]
                    next_r.st = NAMS_WAIT;
                    next_r.cnt = tcount(no_resp_timer); // [RULE12]
                end
            end
            NAMS_WAIT: begin
                if (fd) begin
                    next_r.irq_eon = !target_role || r.rate_ok; // [RULE13]
                    if (!target_role || r.rate_ok) begin
                        next_r.st = NAMS_MASK;
                        next_r.cnt = tcount(mask_timer);
                    end else if (cmd_start_mask_timer) begin
                        next_r.st = NAMS_MASK; // [RULE20]
                        next_r.cnt = tcount(mask_timer);
                    end
                end else if (!target_role && r.cnt == 20'h00000) begin
                    next_r.irq_nre = 1'b1; // [RULE12]
                    next_r.st = NAMS_IDLE;
                end else if (target_role && !fd) begin
                    next_r.st = NAMS_WAIT;
                end
            end
            NAMS_MASK: begin
                if (r.cnt == 20'h00000) begin
                    next_r.rx_watch = 1'b1; // [RULE13]
                    next_r.st = NAMS_RECV;
                end
            end
            NAMS_RECV: begin
                if (rx_go && target_role && rate_detect_mode && !r.normal && !r.rate_ok) begin
                    next_r.irq_sor = 1'b1; // [RULE19]
                    next_r.irq_nfct = 1'b1;
                    next_r.det_rate = r.rate_s1; // [RULE18]
                    next_r.rate_ok = 1'b1;
                end
                if (fd_fall) begin
                    next_r.irq_eof = 1'b1; // [RULE14]
                    next_r.rx_watch = 1'b0;
                    if (auto_response_enable && (!target_role || r.rate_ok ||
                        r.normal || !rate_detect_mode)) begin
                        next_r.st = NAMS_CA; // [RULE3] [RULE14] [RULE19]
                        next_r.resp = 1'b1;
                        next_r.use_ca_thr = 1'b1;
                        next_r.cnt = 20'(`NAMS_CA_CYC);
                    end else begin
                        next_r.st = NAMS_IDLE;
                    end
                end
            end
            default: begin
                next_r.st = NAMS_IDLE;
            end
        endcase
        if (!nfc_mode && !target_role) begin
            next_r.st = NAMS_IDLE;
            next_r.tx_on = 1'b0;
            next_r.rx_watch = 1'b0;
            next_r.use_ca_thr = 1'b0;
        end
    end

    // rate in use: detected in rate mode, else definition
    always_comb begin
        next_div_q = rate_div((target_role && !r.normal && r.rate_ok) ? r.det_rate :
            r.def_rate); // [RULE2] [RULE18]
    end

    // state registers, async reset to constants only
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            r <= '{st: NAMS_IDLE, default: '0};
            preset_q <= 3'h0;
            div_q <= 2'h0;
        end else begin
            r <= next_r;
            preset_q <= next_preset_q;
            div_q <= next_div_q;
        end
    end

    // outputs straight from flip-flops
    assign field_detector_enable = r.fde; // [RULE4] [RULE16]
    assign collision_threshold_sel = r.use_ca_thr; // [RULE5]
    assign tx_enable = r.tx_on; // [RULE6]
    assign rx_watch = r.rx_watch;
    // preset bits: am on, pm off, transport frame [RULE8] [RULE9]
    assign am_channel_enable = preset_q[2];
    assign pm_channel_enable = preset_q[1];
    assign transport_frame_enable = preset_q[0];
    assign start_byte = r.sbyte; // [RULE23]
    assign detected_rate = r.det_rate; // [RULE18]
    assign bit_rate_def = r.def_rate; // [RULE21]
    assign clock_div_sel = div_q; // [RULE2]
    assign low_power = r.lowpow; // [RULE17]
    // event strobes, one cycle each; field-on lasts two if a rate_ok target sees the field rise in idle
    assign irq_collision_done = r.irq_cat;
    assign irq_collision_found = r.irq_cac;
    assign irq_field_on = r.irq_eon;
    assign irq_field_off = r.irq_eof;
    assign irq_no_response = r.irq_nre;
    assign irq_rx_start = r.irq_sor;
    assign irq_rate_detected = r.irq_nfct;

    // checkpoints of the loop, shared by the checks below
    // guard time over while the block is still enabled
    sequence s_guard_done;
        (r.st == NAMS_GUARD) && (r.cnt == 20'h00000) && (nfc_mode || target_role);
    endsequence
    // field hold after the message has run out
    sequence s_hold_done;
        (r.st == NAMS_HOLD) && (r.cnt == 20'h00000) && (nfc_mode || target_role);
    endsequence
    // initiator heard nothing before the no-response count ended
    sequence s_wait_expired;
        (r.st == NAMS_WAIT) && !fd && !target_role && nfc_mode && (r.cnt == 20'h00000);
    endsequence
    // mask time over, receiver may be watched
    sequence s_mask_done;
        (r.st == NAMS_MASK) && (r.cnt == 20'h00000) && (nfc_mode || target_role);
    endsequence

    // transmitter only comes on out of collision avoidance
    a_tx_from_avoid: assert property (@(posedge clock) disable iff (!rstn) // [RULE6]
        $rose(tx_enable) |-> $past(collision_threshold_sel))
        else $error("tx enable rose outside collision avoidance");

    // avoidance threshold is held only while avoidance runs
    a_ca_threshold: assert property (@(posedge clock) disable iff (!rstn) // [RULE5]
        collision_threshold_sel |-> (r.st == NAMS_CA))
        else $error("collision threshold selected outside avoidance");

    // guard over: field stays on and done strobes once
    a_guard_done: assert property (@(posedge clock) disable iff (!rstn) // [RULE11]
        s_guard_done |=> (irq_collision_done && tx_enable))
        else $error("collision avoidance done missing after guard");

    // hold over: field drops and the no-response wait begins
    a_hold_field_off: assert property (@(posedge clock) disable iff (!rstn) // [RULE7]
        s_hold_done |=> (!tx_enable && (r.st == NAMS_WAIT)))
        else $error("field still on after hold time");

    // silent peer gives the no-response strobe
    a_no_response: assert property (@(posedge clock) disable iff (!rstn) // [RULE12]
        s_wait_expired |=> irq_no_response)
        else $error("no-response strobe missing");

    // field-on strobe stretches over two cycles only when a rate_ok target sees the field rise in idle
    a_field_on_once: assert property (@(posedge clock) disable iff (!rstn) // [RULE24]
        irq_field_on |=> !irq_field_on)
        else $error("field-on strobe held for two cycles");

    // receiver watched as soon as mask time is over
    a_mask_watch: assert property (@(posedge clock) disable iff (!rstn) // [RULE13]
        s_mask_done |=> rx_watch)
        else $error("receiver not watched after mask time");

    // detected rate is the synchronised rate at frame start
    a_rate_loaded: assert property (@(posedge clock) disable iff (!rstn) // [RULE19]
        irq_rate_detected |-> (irq_rx_start && (detected_rate == $past(r.rate_s1))))
        else $error("detected rate not loaded with its strobe");

    // detector follows nfc mode and target role
    a_detector_on: assert property (@(posedge clock) disable iff (!rstn) // [RULE4]
        (nfc_mode || target_role) |=> field_detector_enable)
        else $error("field detector not enabled");

    // idle target with no operation bits rests in low power
    a_low_power: assert property (@(posedge clock) disable iff (!rstn) // [RULE17]
        (target_role && (operation_bits == 4'h0)) |=> low_power)
        else $error("low power not entered");

endmodule
`default_nettype wire

// *** verif/nams_peer_model.sv ***
// remote peer model: rf field, frame start and bit rate
`timescale 1ns/1ps
`default_nettype none
module nams_peer_model (
    input wire logic clock,
    output logic field_detect_in,
    output logic rx_start_in,
    output logic [1:0] rate_in
);
    logic [1:0] last_rate;
    initial begin
        field_detect_in = 1'b0;
        rx_start_in = 1'b0;
        last_rate = 2'h0;
        rate_in = 2'h3;
    end
    // field change lands just after a falling edge
    task automatic set_field(input logic on);
        @(negedge clock);
        field_detect_in = on;
    endtask
    // rate is valid only briefly around the frame start, inverted six cycles after release
    task automatic send_frame(input logic [1:0] rate);
        @(negedge clock);
        rx_start_in = 1'b1;
        rate_in = rate;
        last_rate = rate;
        @(negedge clock);
        rx_start_in = 1'b0;
        repeat (6) @(negedge clock);
        rate_in = ~last_rate;
    endtask
endmodule
`default_nettype wire

// *** verif/tb.sv ***
// self-checking bench for the nfc active mode sequencer
`timescale 1ns/1ps
`default_nettype none
`include "nams_regs.svh"
module tb;
    logic clock, rstn, nfc_mode, target_role, rate_detect_mode, auto_response_enable;
    logic slot_hi, slot_lo;
    logic [3:0] operation_bits;
    logic [5:0] cmd;
    logic [15:0] gp, nr, mask;
    logic fde, cts, txe, rxw, am, pm, tfe, lp;
    logic [7:0] sb;
    logic [1:0] drate, brdef, cds;
    logic [6:0] irq;
    logic [9:0] w;
    logic fd, rxs;
    logic [1:0] rin;
    int n_fail = 0, total_checks = 0, cyc = 0, lca;
    int exp_rate[$];
    nams_peer_model peer (.clock(clock), .field_detect_in(fd), .rx_start_in(rxs), .rate_in(rin));
    nams_core uut (.clock(clock), .rstn(rstn), .nfc_mode(nfc_mode), .target_role(target_role),
        .rate_detect_mode(rate_detect_mode), .operation_bits(operation_bits),
        .auto_response_enable(auto_response_enable), .response_slot_count_hi(slot_hi),
        .response_slot_count_lo(slot_lo), .cmd_initial_field_on(cmd[0]),
        .cmd_response_field_on(cmd[1]), .cmd_start_mask_timer(cmd[2]), .cmd_go_normal(cmd[3]),
        .cmd_analog_preset(cmd[4]), .tx_done(cmd[5]), .gp_timer(gp), .no_resp_timer(nr),
        .mask_timer(mask), .field_detect_in(fd), .rx_start_in(rxs), .rate_in(rin),
        .field_detector_enable(fde), .collision_threshold_sel(cts), .tx_enable(txe),
        .rx_watch(rxw), .am_channel_enable(am), .pm_channel_enable(pm),
        .transport_frame_enable(tfe), .start_byte(sb), .detected_rate(drate),
        .bit_rate_def(brdef), .clock_div_sel(cds), .low_power(lp),
        .irq_collision_done(irq[0]), .irq_collision_found(irq[1]), .irq_field_on(irq[2]),
        .irq_field_off(irq[3]), .irq_no_response(irq[4]), .irq_rx_start(irq[5]),
        .irq_rate_detected(irq[6]));
    // one watch vector so a single wait task serves every event
    assign w = {~txe, rxw, txe, irq};
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    // hang guard, well above the expected run length
    always @(posedge clock) begin
        cyc++;
        if (cyc == 90000) begin
            n_fail++;
            end_of_test();
        end
    end
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk_flag(input logic got, input logic exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_val(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // wait up to lim cycles for watch bit k; want=0 means it must stay quiet
    task automatic expect_evt(input int k, input int lim, input logic want);
        logic seen;
        seen = 1'b0;
        for (int i = 0; i < lim && !seen; i++) begin
            @(negedge clock);
            seen = (w[k] === 1'b1);
        end
        chk_flag(seen, want);
    endtask
    // command strobes are one cycle wide, launched on the falling edge
    task automatic pulse(input int k);
        @(negedge clock);
        cmd[k] = 1'b1;
        @(negedge clock);
        cmd = 6'h00;
    endtask
    task automatic do_reset();
        @(negedge clock);
        rstn = 1'b0;
        repeat (6) @(negedge clock);
        rstn = 1'b1;
        repeat (2) @(negedge clock);
    endtask
    // message sent: field stays on for the gp timer, then drops
    task automatic send_msg();
        gp = 16'h0010 + 16'($urandom % 64);
        nr = 16'h0020 + 16'($urandom % 64);
        pulse(5);
        repeat (gp / 2) @(negedge clock);
        chk_flag(txe, 1'b1);
        expect_evt(9, gp + 40, 1'b1);
    endtask
    initial begin
        void'($urandom(32'ha7e7));
        rstn = 1'b0;
        {nfc_mode, target_role, rate_detect_mode, auto_response_enable} = 4'h0;
        {slot_hi, slot_lo} = 2'h0;
        operation_bits = 4'h0;
        cmd = 6'h00;
        gp = 16'h0010 + 16'($urandom % 64);
        nr = 16'h0020 + 16'($urandom % 64);
        mask = 16'h0008 + 16'($urandom % 32);
        lca = `NAMS_CA_CYC + `NAMS_ARFG_CYC + 200;
        do_reset();
        nfc_mode = 1'b1;
        repeat (3) @(negedge clock);
        chk_flag(fde, 1'b1);
        chk_flag(cts, 1'b0);
        chk_flag(txe, 1'b0);
        pulse(4);
        repeat (3) @(negedge clock);
        chk_flag(am, 1'b1);
        chk_flag(pm, 1'b0);
        chk_flag(tfe, 1'b1);
        chk_val(sb, 8'hf0);
        $display("test setup done");
        auto_response_enable = 1'b1;
        pulse(0);
        repeat (10) @(negedge clock);
        chk_flag(cts, 1'b1);
        expect_evt(7, `NAMS_CA_CYC + 100, 1'b1);
        // the full initial guard is too long to sit out, so reset mid-run
        do_reset();
        pulse(1);
        expect_evt(0, lca, 1'b1);
        chk_flag(txe, 1'b1);
        send_msg();
        expect_evt(4, nr + 40, 1'b1);
        pulse(1);
        expect_evt(0, lca, 1'b1);
        send_msg();
        peer.set_field(1'b1);
        expect_evt(2, 40, 1'b1);
        chk_flag(rxw, 1'b0);
        expect_evt(8, mask + 40, 1'b1);
        peer.set_field(1'b0);
        expect_evt(3, 40, 1'b1);
        expect_evt(0, lca, 1'b1);
        auto_response_enable = 1'b0;
        send_msg();
        peer.set_field(1'b1);
        expect_evt(2, 40, 1'b1);
        expect_evt(8, mask + 40, 1'b1);
        peer.set_field(1'b0);
        expect_evt(3, 40, 1'b1);
        expect_evt(0, lca, 1'b0);
        $display("test initiator loop done");
        for (int r = 0; r < 3; r++) begin
            do_reset();
            {target_role, rate_detect_mode, operation_bits} = 6'h30;
            {slot_hi, slot_lo} = 2'($urandom % 4);
            auto_response_enable = 1'b1;
            mask = 16'h0008 + 16'($urandom % 32);
            repeat (3) @(negedge clock);
            chk_flag(lp, 1'b1);
            chk_flag(fde, 1'b1);
            peer.set_field(1'b1);
            expect_evt(2, 40, 1'b1);
            operation_bits = 4'h7;
            pulse(2);
            expect_evt(8, mask + 40, 1'b1);
            exp_rate.push_back(r);
            // the strobes come while the frame is still being sent
            fork
                peer.send_frame(2'(r));
                expect_evt(5, 40, 1'b1);
                expect_evt(6, 200, 1'b1);
            join
            chk_val(8'(drate), 8'(exp_rate[0]));
            pulse(3);
            repeat (3) @(negedge clock);
            chk_val(8'(cds), 8'(exp_rate[0]));
            chk_val(8'(brdef), 8'(exp_rate.pop_front()));
            peer.set_field(1'b0);
            expect_evt(3, 40, 1'b1);
            expect_evt(0, lca, 1'b1);
        end
        $display("test target rate detection done");
        end_of_test();
    end
endmodule
`default_nettype wire
